// ### ramp_fsk_pkg.sv
// constants, mode codes and state type for the ramp and keying modulator
package ramp_fsk_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int INT_W   = 12;
    localparam int FRAC_W  = 25;
    localparam int N_W     = INT_W + FRAC_W;
    localparam int DEV_W   = 16;
    localparam int SHIFT_W = 4;
    localparam int TIMER_W = 12;
    localparam int STEPS_W = 20;
    localparam int MODE_W  = 2;
    localparam int GAP_W   = 2 * TIMER_W + 1;

    // ************************************************************
    // ramp mode field codes
    // ************************************************************
    localparam logic [MODE_W-1:0] MODE_SAWTOOTH     = 2'h0;
    localparam logic [MODE_W-1:0] MODE_TRIANGLE     = 2'h1;
    localparam logic [MODE_W-1:0] MODE_SINGLE_SAW   = 2'h2;
    localparam logic [MODE_W-1:0] MODE_SINGLE_BURST = 2'h3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [N_W-1:0]     N_RESET     = 37'h0;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 12'h0;
    localparam logic [TIMER_W-1:0] TIMER_ONE   = 12'h1;
    localparam logic [STEPS_W-1:0] STEPS_RESET = 20'h0;
    localparam logic [STEPS_W-1:0] STEPS_ONE   = 20'h1;
    localparam logic [GAP_W-1:0]   GAP_RESET   = 25'h0;
    localparam logic [GAP_W-1:0]   GAP_ONE     = 25'h1;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_UP   = 4'h2,
        ST_DOWN = 4'h4,
        ST_HOLD = 4'h8
    } ramp_state_t;

endpackage : ramp_fsk_pkg

// ### ramp_fsk_modulator.sv
// divide value stepping engine for keying and swept waveforms
//
// Notes on behaviour
// - fsk adds or subtracts shifted deviation per pin
// - deviation is 16 bits, shift is 4 bits
// - psk flips output phase by pin level
// - hops in a leg apply exactly one deviation step; in sawtooth and single sawtooth the hop after a full up leg restores the start, hold hops do nothing
// - hop interval is divider a times divider b
// - hops per leg come from 20-bit count
// - single burst steps up then holds
// - single sawtooth restores start value and keeps
// - sawtooth repeats until ramp disabled
// - triangle steps down a full leg, repeats
// - sweeping starts only once start bit set
// - code 01 triangle, code 11 single burst
// - deviation word is signed
module ramp_fsk_modulator
    import ramp_fsk_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 pfd_tick,
    input  wire logic                 modulation_pin,
    input  wire logic [INT_W-1:0]     center_int,
    input  wire logic [FRAC_W-1:0]    center_frac,
    input  wire logic [DEV_W-1:0]     deviation_word,
    input  wire logic [SHIFT_W-1:0]   deviation_shift,
    input  wire logic [TIMER_W-1:0]   hop_timer_divider_a,
    input  wire logic [TIMER_W-1:0]   hop_timer_divider_b,
    input  wire logic [STEPS_W-1:0]   step_count,
    input  wire logic [MODE_W-1:0]    ramp_mode,
    input  wire logic                 ramp_start,
    input  wire logic                 fsk_enable,
    input  wire logic                 psk_enable,
    output logic      [INT_W-1:0]     div_int,
    output logic      [FRAC_W-1:0]    div_frac,
    output logic                      phase_invert,
    output logic                      ramp_active,
    output logic                      ramp_hop
);

    // ************************************************************
    // helpers
    // ************************************************************
    // sign extend then scale; the shift keeps the sign
    function automatic logic [N_W-1:0] step_of(input logic [DEV_W-1:0]   dev,
                                               input logic [SHIFT_W-1:0] sh);
        logic signed [N_W-1:0] ext;
        ext = {{(N_W-DEV_W){dev[DEV_W-1]}}, dev};
        return N_W'(ext <<< sh);
    endfunction : step_of

    // a divider of zero behaves as one so the timer never stalls
    function automatic logic [TIMER_W-1:0] last_of(input logic [TIMER_W-1:0] d);
        return (d == TIMER_RESET) ? TIMER_RESET : d - TIMER_ONE;
    endfunction : last_of

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    logic pin_meta;
    logic pin_sync;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= modulation_pin;
            pin_sync <= pin_meta;
        end
    end

    // ************************************************************
    // hop timer
    // ************************************************************
    ramp_state_t        state;
    ramp_state_t        next_state;
    logic [TIMER_W-1:0] cnt_a;
    logic [TIMER_W-1:0] cnt_b;
    logic [TIMER_W-1:0] next_cnt_a;
    logic [TIMER_W-1:0] next_cnt_b;
    logic               wrap_a;
    logic               wrap_b;
    logic               hop;

    assign wrap_a = (cnt_a >= last_of(hop_timer_divider_a));
    assign wrap_b = (cnt_b >= last_of(hop_timer_divider_b));
    // both dividers cascade, so one hop per a*b pfd periods
    assign hop    = (state != ST_IDLE) && pfd_tick && wrap_a && wrap_b;

    always_comb begin
        next_cnt_a = cnt_a;
        next_cnt_b = cnt_b;
        if (state == ST_IDLE) begin
            next_cnt_a = TIMER_RESET;
            next_cnt_b = TIMER_RESET;
        end else if (pfd_tick) begin
            if (wrap_a) begin
                next_cnt_a = TIMER_RESET;
                next_cnt_b = wrap_b ? TIMER_RESET : cnt_b + TIMER_ONE;
            end else begin
                next_cnt_a = cnt_a + TIMER_ONE;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_a <= TIMER_RESET;
            cnt_b <= TIMER_RESET;
        end else begin
            cnt_a <= next_cnt_a;
            cnt_b <= next_cnt_b;
        end
    end

    // ************************************************************
    // waveform state machine and divide value
    // ************************************************************
    logic [N_W-1:0]     n_value;
    logic [N_W-1:0]     next_n_value;
    logic [N_W-1:0]     base_value;
    logic [N_W-1:0]     next_base_value;
    logic [STEPS_W-1:0] step_cnt;
    logic [STEPS_W-1:0] next_step_cnt;
    logic [N_W-1:0]     step;
    logic [N_W-1:0]     center;
    logic [N_W-1:0]     fsk_value;
    logic               leg_done;

    assign step     = step_of(deviation_word, deviation_shift);
    assign center   = {center_int, center_frac};
    assign leg_done = (step_cnt >= step_count);
    // pin high shifts up, pin low shifts down; off means plain center
    assign fsk_value = !fsk_enable ? center :
                       pin_sync    ? center + step : center - step;

    always_comb begin
        next_state      = state;
        next_n_value    = n_value;
        next_base_value = base_value;
        next_step_cnt   = step_cnt;
        case (state)
            ST_IDLE: begin
                next_n_value  = fsk_value;
                next_step_cnt = STEPS_RESET;
                if (ramp_start) begin
                    next_state      = ST_UP;
                    next_n_value    = center;
                    next_base_value = center;
                end
            end
            ST_UP: begin
                if (hop) begin
                    if (!leg_done) begin
                        // full 37-bit add lets fraction carry into integer
                        next_n_value  = n_value + step;
                        next_step_cnt = step_cnt + STEPS_ONE;
                        if (next_step_cnt >= step_count) begin
                            if (ramp_mode == MODE_SINGLE_BURST) begin
                                next_state = ST_HOLD;
                            end else if (ramp_mode == MODE_TRIANGLE) begin
                                next_state    = ST_DOWN;
                                next_step_cnt = STEPS_RESET;
                            end
                        end
                    end else begin
                        // the interval after the last step restores the start
                        next_n_value  = base_value;
                        next_step_cnt = STEPS_RESET;
                        if (ramp_mode == MODE_SINGLE_SAW) begin
                            next_state = ST_HOLD;
                        end else if (ramp_mode == MODE_SAWTOOTH) begin
                            next_state = ST_UP;
                        end else begin
                            next_state = ST_HOLD;
                        end
                    end
                end
            end
            ST_DOWN: begin
                if (hop) begin
                    next_n_value  = n_value - step;
                    next_step_cnt = step_cnt + STEPS_ONE;
                    if (next_step_cnt >= step_count) begin
                        next_state    = ST_UP;
                        next_step_cnt = STEPS_RESET;
                    end
                end
            end
            ST_HOLD: begin
                next_n_value = n_value;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // clearing the start bit ends any waveform at once
        if (!ramp_start && state != ST_IDLE) begin
            next_state    = ST_IDLE;
            next_n_value  = fsk_value;
            next_step_cnt = STEPS_RESET;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            n_value    <= N_RESET;
            base_value <= N_RESET;
            step_cnt   <= STEPS_RESET;
        end else begin
            state      <= next_state;
            n_value    <= next_n_value;
            base_value <= next_base_value;
            step_cnt   <= next_step_cnt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic next_phase;

    assign next_phase = psk_enable && pin_sync;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_invert <= 1'b0;
            ramp_hop     <= 1'b0;
        end else begin
            phase_invert <= next_phase;
            ramp_hop     <= hop;
        end
    end

    assign div_int     = n_value[N_W-1:FRAC_W];
    assign div_frac    = n_value[FRAC_W-1:0];
    assign ramp_active = (state != ST_IDLE);

    // ************************************************************
    // checks
    // ************************************************************
    logic [GAP_W-1:0] gap;
    logic [GAP_W-1:0] hop_period;

    assign hop_period = GAP_W'(last_of(hop_timer_divider_a) + TIMER_ONE)
                      * GAP_W'(last_of(hop_timer_divider_b) + TIMER_ONE);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap <= GAP_RESET;
        end else if (state == ST_IDLE || hop) begin
            gap <= GAP_RESET;
        end else if (pfd_tick) begin
            gap <= gap + GAP_ONE;
        end
    end

    fsk_shift_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_IDLE && !ramp_start && fsk_enable) |=>
        (n_value == ($past(pin_sync) ? $past(center) + $past(step)
                                     : $past(center) - $past(step))))
        else $error("fsk divide value wrong");

    step_sign_a: assert property (@(posedge clk) disable iff (sys_rst)
        (deviation_word[DEV_W-1]) |-> step[N_W-1])
        else $error("negative deviation not sign extended");

    psk_phase_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(pin_sync) && psk_enable ##1 psk_enable |-> phase_invert)
        else $error("phase did not invert");

    hop_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
        hop && $stable(hop_timer_divider_a) && $stable(hop_timer_divider_b)
        && $past(state) != ST_IDLE |-> (gap + GAP_ONE) == hop_period)
        else $error("hop interval wrong");

    up_step_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_UP && hop && !leg_done && ramp_start) |=>
        n_value == $past(n_value) + $past(step))
        else $error("up step not one deviation");

    burst_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_HOLD && ramp_start) ##1 ramp_start |-> $stable(n_value))
        else $error("held value moved");

    saw_restore_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_UP && hop && leg_done && ramp_start) |=>
        n_value == $past(base_value))
        else $error("sawtooth did not restore");

    tri_turn_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_UP && hop && ramp_start && ramp_mode == MODE_TRIANGLE
         && step_cnt + STEPS_ONE == step_count) |=> state == ST_DOWN)
        else $error("triangle did not turn");

    start_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ramp_start |=> state == ST_IDLE && !ramp_active)
        else $error("ramp ran without start");

    step_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_DOWN) |-> step_cnt < step_count)
        else $error("down leg overran step count");

    tri_down_c: cover property (@(posedge clk) disable iff (sys_rst)
        state == ST_DOWN ##1 state == ST_UP);
    saw_loop_c: cover property (@(posedge clk) disable iff (sys_rst)
        state == ST_UP && hop && leg_done && ramp_mode == MODE_SAWTOOTH);
    fsk_toggle_c: cover property (@(posedge clk) disable iff (sys_rst)
        state == ST_IDLE && fsk_enable && $changed(pin_sync));

endmodule : ramp_fsk_modulator

// ### host_model.sv
// host controller model: programs the modulator settings and drives the keying pin
module host_model
    import ramp_fsk_pkg::*;
(
    input  wire logic                clk,
    output logic                     modulation_pin,
    output logic     [INT_W-1:0]     center_int,
    output logic     [FRAC_W-1:0]    center_frac,
    output logic     [DEV_W-1:0]     deviation_word,
    output logic     [SHIFT_W-1:0]   deviation_shift,
    output logic     [TIMER_W-1:0]   hop_timer_divider_a,
    output logic     [TIMER_W-1:0]   hop_timer_divider_b,
    output logic     [STEPS_W-1:0]   step_count,
    output logic     [MODE_W-1:0]    ramp_mode,
    output logic                     ramp_start,
    output logic                     fsk_enable,
    output logic                     psk_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    // fraction near full scale so keying steps carry into the integer part
    initial begin
        {modulation_pin, ramp_start, fsk_enable, psk_enable} = 4'h0;
        center_int = 12'h100;
        center_frac = 25'h1FFFF00;
        {deviation_word, deviation_shift} = 20'h00010;
        {hop_timer_divider_a, hop_timer_divider_b} = 24'h001001;
        step_count = 20'h00002;
        ramp_mode = 2'h0;
    end

    task automatic set_keying(input logic [DEV_W-1:0] dev, input logic [SHIFT_W-1:0] sh,
                              input logic fsk, input logic psk);
        @(negedge clk);
        deviation_word = dev;
        deviation_shift = sh;
        fsk_enable = fsk;
        psk_enable = psk;
    endtask : set_keying

    task automatic drive_pin(input logic v);
        @(negedge clk);
        modulation_pin = v;
    endtask : drive_pin

    // caller keeps steps times step small enough that the integer rise stays within 256
    task automatic program_ramp(input logic [MODE_W-1:0] mode, input logic [DEV_W-1:0] dev,
                                input logic [SHIFT_W-1:0] sh, input logic [TIMER_W-1:0] a,
                                input logic [TIMER_W-1:0] b, input logic [STEPS_W-1:0] steps,
                                input logic [FRAC_W-1:0] cf, input logic [INT_W-1:0] ci);
        @(negedge clk);
        {fsk_enable, psk_enable} = 2'h0;
        step_count = steps;
        @(negedge clk);
        deviation_word = dev;
        deviation_shift = sh;
        @(negedge clk);
        hop_timer_divider_b = b;
        @(negedge clk);
        ramp_mode = mode;
        @(negedge clk);
        hop_timer_divider_a = a;
        @(negedge clk);
        center_int = ci;
        center_frac = cf;
    endtask : program_ramp

    task automatic set_start(input logic v);
        @(negedge clk);
        ramp_start = v;
    endtask : set_start

endmodule : host_model

// ### testbench.sv
// self-checking bench for the ramp and keying modulator
module testbench
    import ramp_fsk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // wide enough for the divide value plus the three flag outputs
    localparam int CHK_W = N_W + 3;

    logic clk;
    logic sys_rst;
    logic pfd_tick;
    logic modulation_pin, ramp_start, fsk_enable, psk_enable;
    logic [INT_W-1:0]   center_int, div_int;
    logic [FRAC_W-1:0]  center_frac, div_frac;
    logic [DEV_W-1:0]   deviation_word;
    logic [SHIFT_W-1:0] deviation_shift;
    logic [TIMER_W-1:0] hop_timer_divider_a, hop_timer_divider_b;
    logic [STEPS_W-1:0] step_count;
    logic [MODE_W-1:0]  ramp_mode;
    logic phase_invert, ramp_active, ramp_hop;
    logic [N_W-1:0]     div;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int seed = 32'h0CA3;

    assign div = {div_int, div_frac};

    host_model host (.clk, .modulation_pin, .center_int, .center_frac, .deviation_word,
        .deviation_shift, .hop_timer_divider_a, .hop_timer_divider_b, .step_count,
        .ramp_mode, .ramp_start, .fsk_enable, .psk_enable);

    ramp_fsk_modulator dut (.clk, .sys_rst, .pfd_tick, .modulation_pin, .center_int,
        .center_frac, .deviation_word, .deviation_shift, .hop_timer_divider_a,
        .hop_timer_divider_b, .step_count, .ramp_mode, .ramp_start, .fsk_enable,
        .psk_enable, .div_int, .div_frac, .phase_invert, .ramp_active, .ramp_hop);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // a pfd tick every second cycle, so a hop interval is 2 * a * b clocks
    initial pfd_tick = 1'b0;
    always @(negedge clk) pfd_tick <= ~pfd_tick;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [CHK_W-1:0] got,
                       input logic [CHK_W-1:0] exp,
                       input string            what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [N_W-1:0] step_of(input logic [DEV_W-1:0] dev,
                                               input logic [SHIFT_W-1:0] sh);
        return {{(N_W-DEV_W){dev[DEV_W-1]}}, dev} << sh;
    endfunction : step_of

    // number of steps above the start value after hop k
    function automatic int mult_of(input logic [MODE_W-1:0] mode, input int k, input int s);
        int p;
        p = k % (2 * s);
        case (mode)
            MODE_SINGLE_BURST: return (k < s) ? k : s;
            MODE_SINGLE_SAW:   return (k <= s) ? k : 0;
            MODE_SAWTOOTH:     return k % (s + 1);
            default:           return (p <= s) ? p : 2 * s - p;
        endcase
    endfunction : mult_of

    task automatic run_keying();
        logic [DEV_W-1:0]   dev;
        logic [SHIFT_W-1:0] sh;
        logic [N_W-1:0]     c;
        c = {center_int, center_frac};
        for (int i = 0; i < 6; i++) begin
            dev = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7FFF : 16'($random(seed));
            sh = (i < 2) ? 4'hF : 4'($random(seed));
            host.set_keying(dev, sh, 1'b1, 1'b0);
            host.drive_pin(1'b1);
            repeat (4) @(negedge clk);
            chk(div, N_W'(c + step_of(dev, sh)), "fsk high");
            host.drive_pin(1'b0);
            repeat (4) @(negedge clk);
            chk(div, N_W'(c - step_of(dev, sh)), "fsk low");
            host.set_keying(dev, sh, 1'b0, 1'b1);
            host.drive_pin(1'b1);
            repeat (4) @(negedge clk);
            chk({phase_invert, div}, {1'b1, c}, "psk high");
            host.drive_pin(1'b0);
            repeat (4) @(negedge clk);
            chk({phase_invert, div}, {1'b0, c}, "psk low");
        end
        $display("test keying done");
    endtask : run_keying

    task automatic run_ramp(input logic [MODE_W-1:0] mode);
        logic [DEV_W-1:0]   dev;
        logic [SHIFT_W-1:0] sh;
        logic [N_W-1:0]     c;
        logic [N_W-1:0]     e;
        int a, b, s, last, n;
        dev = 16'($random(seed));
        sh = 4'({$random(seed)} % 8);
        a = 1 + {$random(seed)} % 3;
        b = 1 + {$random(seed)} % 3;
        s = 2 + {$random(seed)} % 3;
        c = {12'($random(seed)), 25'($random(seed))};
        host.program_ramp(mode, dev, sh, 12'(a), 12'(b), 20'(s),
                          c[FRAC_W-1:0], c[N_W-1:FRAC_W]);
        repeat (3) @(negedge clk);
        chk({ramp_active, div}, {1'b0, c}, "idle before start");
        host.set_start(1'b1);
        last = -1;
        for (int k = 1; k <= 2 * s + 2; k++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (ramp_hop !== 1'b1 && n < 2 * a * b + 4);
            if (ramp_hop === 1'b1) begin
                if (last >= 0) chk(37'(cyc - last), 37'(2 * a * b), "hop gap");
                last = cyc;
            end else begin
                last = -1;
            end
            chk(ramp_hop, 1'b1, "hop seen");
            // the divide value wraps at its own width, as in the device
            e = c + step_of(dev, sh) * N_W'(mult_of(mode, k, s));
            chk(div, e, "hop");
        end
        host.set_start(1'b0);
        repeat (3) @(negedge clk);
        chk({ramp_active, div}, {1'b0, c}, "stopped");
        $display("test ramp mode %0d done", mode);
    endtask : run_ramp

    initial begin
        sys_rst = 1'b1;
        repeat (6) @(negedge clk);
        chk({phase_invert, ramp_active, ramp_hop, div}, 40'h0, "in reset");
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        chk(div, {center_int, center_frac}, "center after reset");
        $display("test reset done");
        run_keying();
        for (int r = 0; r < 8; r++) begin
            run_ramp(2'(r));
        end
        close_out();
    end

endmodule : testbench
